// File: fmb_pkg.sv
// Summary of operation
// RL1: fractional multiply: shifted product, Z/C, two cycles
// RL2: variants differ only in operand signedness
// RL3: jump via Z loads pc, two cycles
// RL4: call via Z loads pc, three cycles
// RL5: skip-equal adds 2 or 3, 1-3 cycles
// RL6: compares set Z,N,V,C,H only, one cycle
// RL7: register bit skips test bit, 1-3 cycles
// RL8: io bit skips test bit, 1-3 cycles
// RL9: taken branch pc+k+1, cycles 1 or 2
// RL10: signed ge/lt branch on N xor V
// RL11: same-higher/lower branch on carry clear/set
// RL12: half-carry branches test H flag
// RL13: t-bit branches test T flag
// RL14: overflow branches test V flag
// RL15: interrupt branches test I flag
// RL16: relative jump/call, returns from stack, 2/3/4
// RL17: equal/not-equal test Z, minus/plus test N
package fmb_pkg;

  // ----------------------------------------------------------------
  // widths and status flag positions
  // ----------------------------------------------------------------
  localparam int PC_W    = 12;   // program counter width in bits, word addresses
  localparam int FLAG_C  = 0;    // carry
  localparam int FLAG_Z  = 1;    // zero
  localparam int FLAG_N  = 2;    // negative
  localparam int FLAG_V  = 3;    // overflow
  localparam int FLAG_S  = 4;    // sign
  localparam int FLAG_H  = 5;    // half carry
  localparam int FLAG_T  = 6;    // transfer bit
  localparam int FLAG_I  = 7;    // global interrupt enable

  // ----------------------------------------------------------------
  // cycle counts and program counter steps
  // ----------------------------------------------------------------
  localparam logic [2:0] CYC_FRAC_MULT_UNSIGNED     = 3'h2;  // fractional multiply
  localparam logic [2:0] CYC_JUMP     = 3'h2;  // relative or indirect jump
  localparam logic [2:0] CYC_CALL     = 3'h3;  // relative or indirect call
  localparam logic [2:0] CYC_RET      = 3'h4;  // returns
  localparam logic [2:0] CYC_ONE      = 3'h1;  // compares, untaken tests
  localparam logic [2:0] CYC_SKIP_1W  = 3'h2;  // skip over one-word instruction
  localparam logic [2:0] CYC_SKIP_2W  = 3'h3;  // skip over two-word instruction
  localparam logic [2:0] CYC_BR_TAKEN = 3'h2;  // taken branch
  localparam logic [PC_W-1:0] PC_STEP    = 12'h001;  // plain advance
  localparam logic [PC_W-1:0] PC_SKIP_1W = 12'h002;  // skip one word
  localparam logic [PC_W-1:0] PC_SKIP_2W = 12'h003;  // skip two words
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0]  ZERO8  = 8'h00;

  // ----------------------------------------------------------------
  // decoded operations
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NONE, OP_FRAC_MULT_UNSIGNED, OP_FRAC_MULT_SIGNED, OP_FRAC_MULT_MIXED,
    OP_JUMP_VIA_Z, OP_CALL_VIA_Z, OP_REL_JUMP, OP_REL_CALL, OP_SUB_RETURN,
    OP_IRQ_RETURN, OP_CMP_SKIP_EQUAL, OP_CMP_REGS, OP_CMP_REGS_CARRY,
    OP_CMP_IMMEDIATE, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET, OP_BRANCH_FLAG_SET,
    OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER,
    OP_BRANCH_LOWER, OP_BRANCH_MINUS, OP_BRANCH_PLUS, OP_BRANCH_GE_SIGNED,
    OP_BRANCH_LT_SIGNED, OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR,
    OP_BRANCH_TBIT_SET, OP_BRANCH_TBIT_CLEAR, OP_BRANCH_OVERFLOW_SET,
    OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED
  } fmb_op_t;

  // request from decode: opcode and operands
  typedef struct packed {
    fmb_op_t         op;        // operation
    logic [7:0]      rd_val;    // first register value
    logic [7:0]      rr_val;    // second register value
    logic [7:0]      imm;       // immediate constant
    logic [2:0]      bit_sel;   // tested bit or status flag index
    logic [PC_W-1:0] offset;    // sign-extended relative offset
  } fmb_req_t;

  // core context sampled with the request
  typedef struct packed {
    logic [PC_W-1:0] pc;        // address of this instruction
    logic [15:0]     z_ptr;     // Z pointer pair
    logic [PC_W-1:0] stack_pc;  // return address on top of stack
    logic [7:0]      io_val;    // addressed I/O register
    logic [7:0]      flags;     // status_flags_reg contents
    logic            next_2w;   // next instruction is two words
  } fmb_ctx_t;

  // results written back to the core
  typedef struct packed {
    logic            pc_we;     // load program counter
    logic [PC_W-1:0] pc_val;
    logic            prod_we;   // write R1:R0
    logic [15:0]     prod_val;
    logic            flags_we;  // write status_flags_reg
    logic [7:0]      flags_val;
    logic            push_we;   // push return address
    logic [PC_W-1:0] push_val;
    logic            pop_re;    // pop return address
  } fmb_res_t;

endpackage

// File: fmb_exec.sv
`timescale 1ns/10ps
module fmb_exec
  import fmb_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     nrst,
  input  wire logic     start,
  input  wire fmb_req_t req,
  input  wire fmb_ctx_t ctx,
  output logic          ready,
  output logic          done,
  output fmb_res_t      res
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_EXEC} fmb_state_t;

  fmb_state_t      state_reg;     // sequencer state
  logic [2:0]      cnt_reg;       // cycles left in this instruction
  fmb_req_t        req_reg;       // latched request
  fmb_ctx_t        ctx_reg;       // latched context
  logic            hit_reg;       // branch or skip condition held
  logic            done_reg;      // completion pulse
  fmb_res_t        res_reg;       // registered write-back
  logic            hit_now;       // condition of incoming request
  logic [2:0]      cyc_now;       // cycle count of incoming request
  fmb_res_t        res_next;      // write-back computed from latch
  logic [PC_W-1:0] pc_inc;        // pc plus one
  logic [PC_W-1:0] pc_rel;        // pc plus offset plus one
  logic [17:0]     mul_full;      // signed 9x9 product
  logic [15:0]     mul_prod;      // raw 16-bit product
  logic [7:0]      cmp_sub;       // subtrahend of compare
  logic            cmp_cin;       // carry in of compare
  logic [8:0]      cmp_diff;      // difference with borrow

  // ----------------------------------------------------------------
  // condition decode
  // ----------------------------------------------------------------
  // does the branch or skip go, given request and context
  function automatic logic cond_of(input fmb_req_t r, input fmb_ctx_t c);
    logic [7:0] f;
    f = c.flags;
    case (r.op)
      // register compare skip
      OP_CMP_SKIP_EQUAL:         cond_of = (r.rd_val == r.rr_val);
      OP_SKIP_REG_BIT_CLEAR:     cond_of = ~r.rr_val[r.bit_sel];
      OP_SKIP_REG_BIT_SET:       cond_of = r.rr_val[r.bit_sel];
      OP_SKIP_IO_BIT_CLEAR:      cond_of = ~c.io_val[r.bit_sel];
      OP_SKIP_IO_BIT_SET:        cond_of = c.io_val[r.bit_sel];
      OP_BRANCH_FLAG_SET:        cond_of = f[r.bit_sel];
      OP_BRANCH_FLAG_CLEAR:      cond_of = ~f[r.bit_sel];
      OP_BRANCH_EQUAL:           cond_of = f[FLAG_Z];
      OP_BRANCH_NOT_EQUAL:       cond_of = ~f[FLAG_Z];
      OP_BRANCH_CARRY_SET,
      OP_BRANCH_LOWER:           cond_of = f[FLAG_C];
      OP_BRANCH_CARRY_CLEAR,
      OP_BRANCH_SAME_HIGHER:     cond_of = ~f[FLAG_C];
      OP_BRANCH_MINUS:           cond_of = f[FLAG_N];
      OP_BRANCH_PLUS:            cond_of = ~f[FLAG_N];
      OP_BRANCH_GE_SIGNED:       cond_of = ~(f[FLAG_N] ^ f[FLAG_V]);
      OP_BRANCH_LT_SIGNED:       cond_of = f[FLAG_N] ^ f[FLAG_V];
      OP_BRANCH_HALFCARRY_SET:   cond_of = f[FLAG_H];
      OP_BRANCH_HALFCARRY_CLEAR: cond_of = ~f[FLAG_H];
      OP_BRANCH_TBIT_SET:        cond_of = f[FLAG_T];
      OP_BRANCH_TBIT_CLEAR:      cond_of = ~f[FLAG_T];
      OP_BRANCH_OVERFLOW_SET:    cond_of = f[FLAG_V];
      OP_BRANCH_OVERFLOW_CLEAR:  cond_of = ~f[FLAG_V];
      OP_BRANCH_IRQ_ENABLED:     cond_of = f[FLAG_I];
      OP_BRANCH_IRQ_DISABLED:    cond_of = ~f[FLAG_I];
      // everything else is unconditional
      default:                   cond_of = 1'b0;
    endcase
  endfunction

  // true for the five skip forms
  function automatic logic is_skip(input fmb_op_t o);
    is_skip = (o == OP_CMP_SKIP_EQUAL) || (o == OP_SKIP_REG_BIT_CLEAR) ||
              (o == OP_SKIP_REG_BIT_SET) || (o == OP_SKIP_IO_BIT_CLEAR) ||
              (o == OP_SKIP_IO_BIT_SET);
  endfunction

  // true for every conditional branch
  function automatic logic is_branch(input fmb_op_t o);
    is_branch = (o >= OP_BRANCH_FLAG_SET) && (o <= OP_BRANCH_IRQ_DISABLED);
  endfunction

  // ----------------------------------------------------------------
  // cycle count of the incoming request
  // ----------------------------------------------------------------
  always_comb begin
    hit_now = cond_of(req, ctx);
    case (req.op)
      // RL1 multiply timing
      OP_FRAC_MULT_UNSIGNED, OP_FRAC_MULT_SIGNED, OP_FRAC_MULT_MIXED: begin
        cyc_now = CYC_FRAC_MULT_UNSIGNED;
      end
      // RL3 jump timing
      OP_JUMP_VIA_Z, OP_REL_JUMP: begin
        cyc_now = CYC_JUMP;
      end
      // RL4 call timing
      OP_CALL_VIA_Z, OP_REL_CALL: begin
        cyc_now = CYC_CALL;
      end
      // RL16 return timing
      OP_SUB_RETURN, OP_IRQ_RETURN: begin
        cyc_now = CYC_RET;
      end
      default: begin
        if (is_skip(req.op)) begin
          // RL5 skip cycles
          cyc_now = !hit_now ? CYC_ONE : (ctx.next_2w ? CYC_SKIP_2W : CYC_SKIP_1W);
        end else if (is_branch(req.op)) begin
          // RL9 branch cycles
          cyc_now = hit_now ? CYC_BR_TAKEN : CYC_ONE;
        end else begin
          // RL6 compare in one cycle
          cyc_now = CYC_ONE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // datapath from the latched request
  // ----------------------------------------------------------------
  always_comb begin
    pc_inc = ctx_reg.pc + PC_STEP;
    // RL9 target pc plus offset plus one
    pc_rel = ctx_reg.pc + req_reg.offset + PC_STEP;
    // RL2 operand signedness per variant
    case (req_reg.op)
      OP_FRAC_MULT_SIGNED: begin
        mul_full = 18'($signed({req_reg.rd_val[7], req_reg.rd_val}) *
                       $signed({req_reg.rr_val[7], req_reg.rr_val}));
      end
      OP_FRAC_MULT_MIXED: begin
        mul_full = 18'($signed({req_reg.rd_val[7], req_reg.rd_val}) *
                       $signed({1'b0, req_reg.rr_val}));
      end
      default: begin
        mul_full = 18'($signed({1'b0, req_reg.rd_val}) *
                       $signed({1'b0, req_reg.rr_val}));
      end
    endcase
    mul_prod = mul_full[15:0];
    // compare subtrahend and carry in
    cmp_sub  = (req_reg.op == OP_CMP_IMMEDIATE) ? req_reg.imm : req_reg.rr_val;
    cmp_cin  = (req_reg.op == OP_CMP_REGS_CARRY) ? ctx_reg.flags[FLAG_C] : 1'b0;
    cmp_diff = {1'b0, req_reg.rd_val} - {1'b0, cmp_sub} - {8'h00, cmp_cin};
  end

  // ----------------------------------------------------------------
  // write-back selection
  // ----------------------------------------------------------------
  always_comb begin
    res_next           = '0;
    res_next.flags_val = ctx_reg.flags;
    case (req_reg.op)
      // RL1 shifted product, Z and C
      OP_FRAC_MULT_UNSIGNED, OP_FRAC_MULT_SIGNED, OP_FRAC_MULT_MIXED: begin
        res_next.prod_we          = 1'b1;
        res_next.prod_val         = {mul_prod[14:0], 1'b0};
        res_next.flags_we         = 1'b1;
        res_next.flags_val[FLAG_C] = mul_prod[15];
        res_next.flags_val[FLAG_Z] = ({mul_prod[14:0], 1'b0} == ZERO16);
      end
      // RL3 jump to Z pointer
      OP_JUMP_VIA_Z: begin
        res_next.pc_we  = 1'b1;
        res_next.pc_val = ctx_reg.z_ptr[PC_W-1:0];
      end
      // RL4 call to Z pointer
      OP_CALL_VIA_Z: begin
        res_next.pc_we    = 1'b1;
        res_next.pc_val   = ctx_reg.z_ptr[PC_W-1:0];
        res_next.push_we  = 1'b1;
        res_next.push_val = pc_inc;
      end
      // RL16 relative jump
      OP_REL_JUMP: begin
        res_next.pc_we  = 1'b1;
        res_next.pc_val = pc_rel;
      end
      // RL16 relative call
      OP_REL_CALL: begin
        res_next.pc_we    = 1'b1;
        res_next.pc_val   = pc_rel;
        res_next.push_we  = 1'b1;
        res_next.push_val = pc_inc;
      end
      // RL16 return from stack
      OP_SUB_RETURN: begin
        res_next.pc_we  = 1'b1;
        res_next.pc_val = ctx_reg.stack_pc;
        res_next.pop_re = 1'b1;
      end
      // interrupt return also re-enables interrupts
      OP_IRQ_RETURN: begin
        res_next.pc_we            = 1'b1;
        res_next.pc_val           = ctx_reg.stack_pc;
        res_next.pop_re           = 1'b1;
        res_next.flags_we         = 1'b1;
        res_next.flags_val[FLAG_I] = 1'b1;
      end
      // RL6 compare flags only
      OP_CMP_REGS, OP_CMP_REGS_CARRY, OP_CMP_IMMEDIATE: begin
        res_next.pc_we             = 1'b1;
        res_next.pc_val            = pc_inc;
        res_next.flags_we          = 1'b1;
        res_next.flags_val[FLAG_C] = cmp_diff[8];
        res_next.flags_val[FLAG_Z] = (cmp_diff[7:0] == ZERO8);
        res_next.flags_val[FLAG_N] = cmp_diff[7];
        res_next.flags_val[FLAG_V] = (req_reg.rd_val[7] & ~cmp_sub[7] & ~cmp_diff[7]) |
                                     (~req_reg.rd_val[7] & cmp_sub[7] & cmp_diff[7]);
        res_next.flags_val[FLAG_H] = (~req_reg.rd_val[3] & cmp_sub[3]) |
                                     (cmp_sub[3] & cmp_diff[3]) |
                                     (cmp_diff[3] & ~req_reg.rd_val[3]);
      end
      default: begin
        res_next.pc_we = 1'b1;
        if (is_skip(req_reg.op) && hit_reg) begin
          // RL7 RL8 skip past next instruction
          res_next.pc_val = ctx_reg.pc + (ctx_reg.next_2w ? PC_SKIP_2W : PC_SKIP_1W);
        end else if (is_branch(req_reg.op) && hit_reg) begin
          // RL10 RL11 RL12 RL13 RL14 RL15 RL17 taken branch
          res_next.pc_val = pc_rel;
        end else begin
          // fall through
          res_next.pc_val = pc_inc;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // state and cycle counter
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_EXEC;
            cnt_reg   <= cyc_now;
          end
        end
        ST_EXEC: begin
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == CYC_ONE) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // request and context latch
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      req_reg <= '0;
      ctx_reg <= '0;
      hit_reg <= 1'b0;
    end else if (start && state_reg == ST_IDLE) begin
      req_reg <= req;
      ctx_reg <= ctx;
      hit_reg <= hit_now;
    end
  end

  // write-back and completion pulse on the last cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      done_reg <= 1'b0;
      res_reg  <= '0;
    end else if (state_reg == ST_EXEC && cnt_reg == CYC_ONE) begin
      done_reg <= 1'b1;
      res_reg  <= res_next;
    end else begin
      done_reg <= 1'b0;
      res_reg  <= '0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ready = (state_reg == ST_IDLE);
  assign done  = done_reg;
  assign res   = res_reg;

endmodule

// File: fmb_exec_assertions.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// answer timing and results at the execute unit ports
// ------------------------------------------------------------
module fmb_exec_assertions
  import fmb_pkg::*;
(
  input wire logic     clock,
  input wire logic     nrst,
  input wire logic     start,
  input wire fmb_req_t req,
  input wire fmb_ctx_t ctx,
  input wire logic     ready,
  input wire logic     done,
  input wire fmb_res_t res
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // a request of one kind is taken
  sequence s_take(fmb_op_t o);
    start && ready && req.op == o;
  endsequence
  // two quiet sampled edges, then the answer of a two-cycle instruction
  sequence s_two;
    !done [*2] ##1 done;
  endsequence
  a_frac_mult_unsigned_two_cycles: assert property (
    start && ready && req.op inside {OP_FRAC_MULT_UNSIGNED, OP_FRAC_MULT_SIGNED,
    OP_FRAC_MULT_MIXED} |=> s_two ##0 (res.prod_we && res.flags_we))
    else $error("multiply answer not after two cycles");
  a_cmp_flags_only: assert property (
    start && ready && req.op inside {OP_CMP_REGS, OP_CMP_REGS_CARRY, OP_CMP_IMMEDIATE}
    |=> !done ##1 (done && res.flags_we && !res.prod_we && !res.push_we))
    else $error("compare answer wrong");
  a_jump_z_target: assert property (
    s_take(OP_JUMP_VIA_Z) |=> s_two ##0 (res.pc_val == $past(ctx.z_ptr[PC_W-1:0], 3)
    && !res.flags_we)) else $error("jump via z wrong");
  a_call_z_push: assert property (
    s_take(OP_CALL_VIA_Z) |=> !done ##1 s_two ##0 (res.push_we
    && res.push_val == $past(ctx.pc, 4) + 12'h001)) else $error("call via z wrong");
  a_return_pop: assert property (
    start && ready && req.op inside {OP_SUB_RETURN, OP_IRQ_RETURN} |=> !done [*2] ##1
    s_two ##0 (res.pop_re && res.pc_val == $past(ctx.stack_pc, 5)))
    else $error("return wrong");
  a_rel_jump_target: assert property (
    s_take(OP_REL_JUMP) |=> s_two ##0
    (res.pc_val == $past(ctx.pc, 3) + $past(req.offset, 3) + 12'h001))
    else $error("relative jump target wrong");
  a_equal_taken: assert property (
    s_take(OP_BRANCH_EQUAL) ##0 ctx.flags[FLAG_Z] |=> s_two ##0 (res.pc_we
    && res.pc_val == $past(ctx.pc, 3) + $past(req.offset, 3) + 12'h001))
    else $error("equal branch not taken in two cycles");
  a_ge_not_taken: assert property (
    s_take(OP_BRANCH_GE_SIGNED) ##0 (ctx.flags[FLAG_N] ^ ctx.flags[FLAG_V])
    |=> !done ##1 (done && res.pc_val == $past(ctx.pc, 2) + 12'h001))
    else $error("ge branch wrong");
  a_skip_two_words: assert property (
    s_take(OP_CMP_SKIP_EQUAL) ##0 (req.rd_val == req.rr_val && ctx.next_2w)
    |=> !done ##1 s_two ##0 (res.pc_val == $past(ctx.pc, 4) + 12'h003))
    else $error("skip over two words wrong");
endmodule
bind fmb_exec fmb_exec_assertions chk_u (.clock(clock), .nrst(nrst), .start(start),
  .req(req), .ctx(ctx), .ready(ready), .done(done), .res(res));

// File: fmb_core_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// core side: offers requests at the falling edge, times answers
// ------------------------------------------------------------
module fmb_core_model
  import fmb_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     ready,
  input  wire logic     done,
  input  wire fmb_res_t res,
  output fmb_req_t      req,
  output fmb_ctx_t      ctx,
  output logic          start
);
  fmb_res_t got; // answer seen in the done cycle
  int       cyc; // edges from taking to answer
  initial begin
    start = 1'b0;
    req   = '0;
    ctx   = '0;
  end
  // drop the strobe; the lines it qualified no longer hold data
  task automatic rest();
    start = 1'b0;
    req   = ~req;
    ctx   = ~ctx;
  endtask
  // hold the request until idle, then count edges to the answer
  task automatic exec(input fmb_req_t r, input fmb_ctx_t c);
    start = 1'b1;
    req   = r;
    ctx   = c;
    while (ready !== 1'b1) @(negedge clock);
    cyc = 0;
    // taken at the edge just passed: release the strobe
    @(negedge clock);
    rest();
    // count edges after the taking edge until done shows
    while (done !== 1'b1 && cyc < 8) begin
      @(negedge clock);
      cyc++;
    end
    got = res;
  endtask
endmodule

// File: frac_mul_branch_skip_exec_tb.sv
`timescale 1ns/10ps
module frac_mul_branch_skip_exec_tb
  import fmb_pkg::*;
();
  logic     clock;
  logic     nrst;     // active low
  logic     start;
  fmb_req_t req;
  fmb_ctx_t ctx;
  logic     ready;
  logic     done;
  fmb_res_t res;
  int       fails;
  int       compares;
  fmb_exec dut_u (.clock(clock), .nrst(nrst), .start(start), .req(req), .ctx(ctx),
    .ready(ready), .done(done), .res(res));
  fmb_core_model core_u (.clock(clock), .ready(ready), .done(done), .res(res),
    .req(req), .ctx(ctx), .start(start));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ----------------------------------------------------------
  // shared compare and request tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // issue at pc 0x100, offset -4, io value is ~a, rr is ~b for compare-immediate
  task automatic tc(input fmb_op_t op, input logic [7:0] a, input logic [7:0] b,
                    input logic [2:0] s, input logic [7:0] fl, input logic nx,
                    input int n, input logic [11:0] pcv);
    core_u.exec('{op, a, (op == OP_CMP_IMMEDIATE) ? ~b : b, b, s, 12'hFFC},
                '{12'h100, 16'hA5C3, 12'h2E7, ~a, fl, nx});
    chk(core_u.cyc, n);
    if (op > OP_FRAC_MULT_MIXED) chk(core_u.got.pc_val, pcv);
  endtask
  task automatic t_frac_mult_unsigned();
    @(negedge clock);
    tc(OP_FRAC_MULT_UNSIGNED, 8'hFF, 8'hFF, 3'h0, 8'hF0, 1'b0, 2, 12'h000);
    chk({core_u.got.prod_val, core_u.got.flags_val}, 24'hFC02_F1);
    tc(OP_FRAC_MULT_SIGNED, 8'hFF, 8'hFF, 3'h0, 8'h03, 1'b0, 2, 12'h000);
    chk({core_u.got.prod_val, core_u.got.flags_val}, 24'h0002_00);
    tc(OP_FRAC_MULT_MIXED, 8'hFF, 8'hFF, 3'h0, 8'h00, 1'b0, 2, 12'h000);
    chk({core_u.got.prod_val, core_u.got.flags_val}, 24'hFE02_01);
    tc(OP_FRAC_MULT_UNSIGNED, 8'h00, 8'h37, 3'h0, 8'h01, 1'b0, 2, 12'h000);
    chk({core_u.got.prod_val, core_u.got.flags_val}, 24'h0000_02);
    core_u.rest();
    $display("test frac_mult_unsigned done");
  endtask
  task automatic t_flow();
    @(negedge clock);
    tc(OP_JUMP_VIA_Z, 8'h00, 8'h00, 3'h0, 8'h00, 1'b0, 2, 12'h5C3);
    chk(core_u.got.flags_we, 0);
    tc(OP_CALL_VIA_Z, 8'h00, 8'h00, 3'h0, 8'h00, 1'b0, 3, 12'h5C3);
    chk({core_u.got.push_we, core_u.got.push_val}, 13'h1101);
    tc(OP_REL_JUMP, 8'h00, 8'h00, 3'h0, 8'h00, 1'b0, 2, 12'h0FD);
    tc(OP_REL_CALL, 8'h00, 8'h00, 3'h0, 8'h00, 1'b0, 3, 12'h0FD);
    tc(OP_SUB_RETURN, 8'h00, 8'h00, 3'h0, 8'h00, 1'b0, 4, 12'h2E7);
    tc(OP_IRQ_RETURN, 8'h00, 8'h00, 3'h0, 8'h00, 1'b0, 4, 12'h2E7);
    chk({core_u.got.pop_re, core_u.got.flags_we, core_u.got.flags_val}, 10'h380);
    core_u.rest();
    $display("test flow done");
  endtask
  task automatic t_cmp();
    @(negedge clock);
    tc(OP_CMP_REGS, 8'h10, 8'h20, 3'h0, 8'hC0, 1'b0, 1, 12'h101);
    chk({core_u.got.prod_val, core_u.got.flags_val}, 24'h0000_C5);
    tc(OP_CMP_REGS_CARRY, 8'h20, 8'h20, 3'h0, 8'h01, 1'b0, 1, 12'h101);
    chk(core_u.got.flags_val, 8'h25);
    tc(OP_CMP_IMMEDIATE, 8'h80, 8'h01, 3'h0, 8'h10, 1'b0, 1, 12'h101);
    chk({core_u.got.prod_we, core_u.got.flags_val}, 9'h038);
    core_u.rest();
    $display("test compare done");
  endtask
  task automatic t_skip();
    @(negedge clock);
    tc(OP_CMP_SKIP_EQUAL, 8'h5A, 8'h5A, 3'h0, 8'h00, 1'b0, 2, 12'h102);
    tc(OP_CMP_SKIP_EQUAL, 8'h5A, 8'h5A, 3'h0, 8'h00, 1'b1, 3, 12'h103);
    tc(OP_CMP_SKIP_EQUAL, 8'h5A, 8'h5B, 3'h0, 8'h00, 1'b1, 1, 12'h101);
    tc(OP_SKIP_REG_BIT_CLEAR, 8'hFF, 8'h7F, 3'h7, 8'h00, 1'b1, 3, 12'h103);
    tc(OP_SKIP_REG_BIT_SET, 8'h7F, 8'h7F, 3'h7, 8'h00, 1'b1, 1, 12'h101);
    tc(OP_SKIP_REG_BIT_SET, 8'h00, 8'h01, 3'h0, 8'h00, 1'b0, 2, 12'h102);
    tc(OP_SKIP_IO_BIT_CLEAR, 8'h01, 8'h01, 3'h1, 8'h00, 1'b0, 1, 12'h101);
    tc(OP_SKIP_IO_BIT_CLEAR, 8'h02, 8'h02, 3'h1, 8'h00, 1'b0, 2, 12'h102);
    tc(OP_SKIP_IO_BIT_SET, 8'h7F, 8'h7F, 3'h7, 8'h00, 1'b1, 3, 12'h103);
    core_u.rest();
    $display("test skip done");
  endtask
  // each branch kind first with its condition met (taken), then not met
  task automatic t_branch();
    fmb_op_t    bop [20] = '{OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL, OP_BRANCH_CARRY_SET,
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER, OP_BRANCH_MINUS,
      OP_BRANCH_PLUS, OP_BRANCH_GE_SIGNED, OP_BRANCH_LT_SIGNED, OP_BRANCH_HALFCARRY_SET,
      OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_TBIT_SET, OP_BRANCH_TBIT_CLEAR,
      OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ENABLED,
      OP_BRANCH_IRQ_DISABLED, OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR};
    logic [2:0] bix [20] = '{1, 1, 0, 0, 0, 0, 2, 2, 2, 2, 5, 5, 6, 6, 3, 3, 7, 7, 6, 3};
    logic       pol [20] = '{1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0};
    logic [7:0] fb;
    @(negedge clock);
    for (int i = 0; i < 20; i++) begin
      fb = 8'h01 << bix[i];
      tc(bop[i], 8'h00, 8'h00, bix[i], pol[i] ? fb : 8'h00, 1'b0, 2, 12'h0FD);
      tc(bop[i], 8'h00, 8'h00, bix[i], pol[i] ? 8'h00 : fb, 1'b0, 1, 12'h101);
    end
    tc(OP_BRANCH_GE_SIGNED, 8'h00, 8'h00, 3'h0, 8'h0C, 1'b0, 2, 12'h0FD);
    tc(OP_BRANCH_LT_SIGNED, 8'h00, 8'h00, 3'h0, 8'h0C, 1'b0, 1, 12'h101);
    core_u.rest();
    $display("test branch done");
  endtask
  // reset in mid-call: no answer, then normal service again
  task automatic t_reset();
    @(negedge clock);
    fork
      core_u.exec('{OP_REL_CALL, 8'h00, 8'h00, 8'h00, 3'h0, 12'h010}, '0);
      begin
        @(negedge clock);
        nrst = 1'b0;
        @(negedge clock);
        chk({ready, done, res === '0}, 3'h5);
        nrst = 1'b1;
      end
    join
    chk(core_u.cyc, 8);
    tc(OP_CMP_REGS, 8'h20, 8'h10, 3'h0, 8'h00, 1'b0, 1, 12'h101);
    core_u.rest();
    $display("test reset done");
  endtask
  task automatic results();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #250000;
    fails++;
    results();
  end
  initial begin
    fails    = 0;
    compares = 0;
    nrst     = 1'b0;
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    t_frac_mult_unsigned();
    t_flow();
    t_cmp();
    t_skip();
    t_branch();
    t_reset();
    results();
  end
endmodule
